// *** hdl/sahi_pkg.sv ***
// constants and state codes for the converter control and host interface
// assumes one 40 MHz clock, all pins already synchronous to it
package sahi_pkg;

    // =========================================================
    // widths
    localparam int RESULT_W = 8;
    localparam int CHAN_W = 3;
    localparam int NUM_CHAN = 8;
    localparam int CNT_W = 7;
    localparam int CLK_HZ = 40000000;

    // =========================================================
    // sequence edge numbers, counted from one after start falls
    localparam logic [CNT_W-1:0] CNT_FIRST = 7'h01;
    localparam logic [CNT_W-1:0] CNT_SAMPLE_OPEN = 7'h04;
    localparam logic [CNT_W-1:0] CNT_CONV_START = 7'h08;
    localparam logic [CNT_W-1:0] CNT_RESULT = 7'h40;
    localparam logic [CNT_W-1:0] CNT_DONE = 7'h41;
    localparam int BIT_CLKS = 7;
    localparam logic [2:0] STEP_LAST = 3'(BIT_CLKS - 1);
    localparam logic [2:0] BIT_MSB = 3'(RESULT_W - 1);

    // =========================================================
    // reset values, and the trial code loaded at conversion start
    localparam logic [RESULT_W-1:0] RESULT_RESET = 8'h00;
    localparam logic [RESULT_W-1:0] TRIAL_MSB = 8'h80;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;

    // =========================================================
    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_HOLD   = 6'b000010,
        ST_WAIT   = 6'b000100,
        ST_SAMPLE = 6'b001000,
        ST_CONV   = 6'b010000,
        ST_DONE   = 6'b100000
    } sahi_state_t;

endpackage

// *** hdl/sahi_sar_step.sv ***
// one successive-approximation step on the trial code
// assumes the caller only asks for a step inside the decision phase
`timescale 1ns/1ps
module sahi_sar_step
    import sahi_pkg::*;
#(
    parameter int W = RESULT_W
) (
    // trial code and decision
    input wire logic [W-1:0] trial_in,
    input wire logic [2:0] bit_idx_in,
    input wire logic keep_in,
    // code after the decision
    output logic [W-1:0] next_out
);

    // =========================================================
    // clear the bit under test if rejected, then try the next lower bit
    always_comb begin
        next_out = trial_in;
        if (!keep_in) begin
            next_out[bit_idx_in] = 1'b0;
        end
        if (bit_idx_in != 3'h0) begin
            next_out[bit_idx_in - 3'h1] = 1'b1;
        end
    end

endmodule

// *** hdl/sahi_top.sv ***
// control and host interface of an 8-bit successive-approximation converter
// assumes synchronous pins, a comparator output valid on every clock and
// an external bus buffer resolving result_bus_out with result_bus_oe_out
`timescale 1ns/1ps
module sahi_top
    import sahi_pkg::*;
#(
    parameter int W = RESULT_W
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // channel selection
    input wire logic [CHAN_W-1:0] channel_select_in,
    input wire logic addr_latch_in,
    output logic [NUM_CHAN-1:0] channel_onehot_out,
    // conversion control
    input wire logic start_in,
    input wire logic comparator_in,
    output logic sample_out,
    output logic [W-1:0] trial_code_out,
    output logic conv_done_out,
    // result bus
    input wire logic output_enable_in,
    output logic [W-1:0] result_bus_out,
    output logic result_bus_oe_out
);

    // =========================================================
    // helpers
    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    sahi_state_t state_reg;
    logic [CHAN_W-1:0] chan_reg;
    logic ale_q_reg;
    logic start_q_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [2:0] step_reg;
    logic [2:0] bit_idx_reg;
    logic [W-1:0] trial_reg;
    logic [W-1:0] trial_next;
    logic [W-1:0] result_reg;
    logic sample_reg;
    logic conv_done_reg;
    logic decide;
    logic start_rise;

    assign cnt_next = cnt_reg + CNT_FIRST;
    assign decide = (state_reg == ST_CONV) && (step_reg == STEP_LAST) && !start_in;
    assign start_rise = rise(start_in, start_q_reg);

    // =========================================================
    // channel latch and decoder
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ale_q_reg <= 1'b0;
            chan_reg <= CHAN_RESET;
        end else begin
            ale_q_reg <= addr_latch_in;
            if (rise(addr_latch_in, ale_q_reg)) begin
                chan_reg <= channel_select_in;
            end
        end
    end

    // plain binary decode, one enable per analog channel
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            channel_onehot_out <= '0;
        end else begin
            channel_onehot_out <= NUM_CHAN'(1) << chan_reg;
        end
    end

    // =========================================================
    // sequencer: start high holds everything, edges counted after the fall
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            start_q_reg <= 1'b0;
        end else begin
            start_q_reg <= start_in;
            if (start_in) begin
                // abort whatever runs; level, so a long pulse keeps it reset
                state_reg <= ST_HOLD;
                cnt_reg <= '0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        state_reg <= ST_IDLE;
                    end
                    ST_HOLD: begin
                        state_reg <= ST_WAIT;
                        cnt_reg <= CNT_FIRST;
                    end
                    ST_WAIT: begin
                        cnt_reg <= cnt_next;
                        if (cnt_next == CNT_SAMPLE_OPEN) begin
                            state_reg <= ST_SAMPLE;
                        end
                    end
                    ST_SAMPLE: begin
                        cnt_reg <= cnt_next;
                        if (cnt_next == CNT_CONV_START) begin
                            state_reg <= ST_CONV;
                        end
                    end
                    ST_CONV: begin
                        cnt_reg <= cnt_next;
                        if (cnt_next == CNT_RESULT) begin
                            state_reg <= ST_DONE;
                        end
                    end
                    ST_DONE: begin
                        cnt_reg <= cnt_next;
                        state_reg <= ST_IDLE;
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // =========================================================
    // sampling switch, closed for four periods
    always_ff @(posedge clk_in) begin
        if (srst_in || start_in) begin
            sample_reg <= 1'b0;
        end else if (state_reg == ST_WAIT && cnt_next == CNT_SAMPLE_OPEN) begin
            sample_reg <= 1'b1;
        end else if (state_reg == ST_SAMPLE && cnt_next == CNT_CONV_START) begin
            sample_reg <= 1'b0;
        end
    end

    // =========================================================
    // successive approximation register, msb first
    sahi_sar_step #(
        .W(W)
    ) u_step (
        .trial_in(trial_reg),
        .bit_idx_in(bit_idx_reg),
        .keep_in(comparator_in),
        .next_out(trial_next)
    );

    always_ff @(posedge clk_in) begin
        if (srst_in || start_in) begin
            trial_reg <= '0;
            step_reg <= 3'h0;
            bit_idx_reg <= BIT_MSB;
        end else if (state_reg == ST_SAMPLE && cnt_next == CNT_CONV_START) begin
            trial_reg <= TRIAL_MSB;
            step_reg <= 3'h0;
            bit_idx_reg <= BIT_MSB;
        end else if (state_reg == ST_CONV) begin
            if (decide) begin
                // seven periods per bit, then move one bit down
                trial_reg <= trial_next;
                step_reg <= 3'h0;
                bit_idx_reg <= bit_idx_reg - 3'h1;
            end else begin
                step_reg <= step_reg + 3'h1;
            end
        end
    end

    // =========================================================
    // holding register: untouched by start so the old value stays readable
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            result_reg <= RESULT_RESET;
        end else if (decide && cnt_next == CNT_RESULT) begin
            result_reg <= trial_next;
        end
    end

    // done flag: high out of reset, low during decisions
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            conv_done_reg <= 1'b1;
        end else if (!start_in && state_reg == ST_SAMPLE && cnt_next == CNT_CONV_START) begin
            conv_done_reg <= 1'b0;
        end else if (!start_in && state_reg == ST_DONE) begin
            conv_done_reg <= 1'b1;
        end
    end

    // =========================================================
    // outputs; the enable is combinational so the bus floats at once
    assign sample_out = sample_reg;
    assign trial_code_out = trial_reg;
    assign conv_done_out = conv_done_reg;
    assign result_bus_out = result_reg;
    assign result_bus_oe_out = output_enable_in;

    // =========================================================
    // assertions
    latch_capture_a: assert property (@(posedge clk_in) disable iff (srst_in)
        rise(addr_latch_in, ale_q_reg) |=> chan_reg == $past(channel_select_in))
        else $error("channel not captured on latch strobe");

    // decoder output lags the latch by one edge, so compare with last edge's number
    decode_sel_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $stable(chan_reg) |=> channel_onehot_out == (NUM_CHAN'(1) << $past(chan_reg))
            && $onehot(channel_onehot_out))
        else $error("channel decode wrong");

    hold_reset_a: assert property (@(posedge clk_in) disable iff (srst_in)
        start_rise |=> state_reg == ST_HOLD && cnt_reg == '0 && !sample_reg)
        else $error("start edge did not reset sequence");

    start_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        start_in ##1 !start_in |=> cnt_reg == CNT_FIRST)
        else $error("count did not begin at one after start fell");

    // a restart inside the window legally cuts it short
    sample_window_a: assert property (@(posedge clk_in) disable iff (srst_in || start_in)
        $rose(sample_reg) |-> cnt_reg == CNT_SAMPLE_OPEN ##0 sample_reg[*4] ##1 !sample_reg)
        else $error("sampling window not four periods from edge 4");

    eoc_low_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(conv_done_reg) |-> cnt_reg == CNT_CONV_START && trial_reg == TRIAL_MSB)
        else $error("done flag fell at wrong edge");

    bit_time_a: assert property (@(posedge clk_in) disable iff (srst_in || start_in)
        decide |=> !decide[*6])
        else $error("bit decision spacing not seven periods");

    result_load_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $changed(result_reg) |-> cnt_reg == CNT_RESULT && !conv_done_reg)
        else $error("result loaded at wrong edge");

    eoc_high_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(conv_done_reg) |-> cnt_reg == CNT_DONE && state_reg == ST_IDLE)
        else $error("done flag rose at wrong edge");

    keep_result_a: assert property (@(posedge clk_in) disable iff (srst_in)
        start_in |=> $stable(result_reg))
        else $error("stored result disturbed by start");

    bus_float_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !output_enable_in |-> !result_bus_oe_out)
        else $error("bus driven while output enable low");

    idle_stay_a: assert property (@(posedge clk_in) disable iff (srst_in)
        state_reg == ST_IDLE && !start_in |=> state_reg == ST_IDLE && $stable(cnt_reg))
        else $error("sequencer left idle without start");

    full_conv_c: cover property (@(posedge clk_in) disable iff (srst_in)
        $rose(conv_done_reg) && result_reg != RESULT_RESET);
    abort_c: cover property (@(posedge clk_in) disable iff (srst_in)
        state_reg == ST_CONV && start_in);
    read_bus_c: cover property (@(posedge clk_in) disable iff (srst_in)
        conv_done_reg && output_enable_in);
    latch_c: cover property (@(posedge clk_in) disable iff (srst_in)
        rise(addr_latch_in, ale_q_reg) && channel_select_in == 3'h7);

endmodule

// *** verification/sahi_cmp_model.sv ***
// comparator and analog source standing at the converter's far side
// assumes the trial code is a settled register output of the sequencer
`timescale 1ns/1ps
module sahi_cmp_model
    import sahi_pkg::*;
(
    // analog level, expressed as the ideal code
    input wire logic [RESULT_W-1:0] level_in,
    // trial code from the sequencer
    input wire logic [RESULT_W-1:0] trial_in,
    // decision back to the sequencer
    output logic keep_out
);
    // =========================================================
    // ideal comparator
    // purely combinational, so any decision edge sees the settled answer
    assign keep_out = (level_in >= trial_in);
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the converter control and host interface
// assumes one 40 MHz clock; the far side is an ideal comparator model
`timescale 1ns/1ps
module tb_top;
    import sahi_pkg::*;
    // =========================================================
    // stimulus and observed signals
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [CHAN_W-1:0] channel_select_in = 3'h0;
    logic addr_latch_in = 1'b0;
    logic start_in = 1'b0;
    logic output_enable_in = 1'b0;
    logic [RESULT_W-1:0] level = 8'h00;
    logic comparator_in;
    logic [NUM_CHAN-1:0] channel_onehot_out;
    logic sample_out;
    logic [RESULT_W-1:0] trial_code_out;
    logic conv_done_out;
    logic [RESULT_W-1:0] result_bus_out;
    logic result_bus_oe_out;
    int n_fail = 0;
    int compares = 0;

    // =========================================================
    // clock and instances
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    sahi_top sahi_top_i (
        .clk_in(clk_in), .srst_in(srst_in),
        .channel_select_in(channel_select_in), .addr_latch_in(addr_latch_in),
        .channel_onehot_out(channel_onehot_out), .start_in(start_in),
        .comparator_in(comparator_in), .sample_out(sample_out),
        .trial_code_out(trial_code_out), .conv_done_out(conv_done_out),
        .output_enable_in(output_enable_in), .result_bus_out(result_bus_out),
        .result_bus_oe_out(result_bus_oe_out)
    );

    sahi_cmp_model sahi_cmp_model_i (
        .level_in(level), .trial_in(trial_code_out), .keep_out(comparator_in)
    );

    // =========================================================
    // shared helpers
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // start held high for n sampled edges; sequencer must stay cleared
    task automatic pulse_start(input int n, input logic d0);
        @(posedge clk_in) start_in <= 1'b1;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk_in);
            // dropped on the last high sample's edge, so the next edge is edge one
            if (i == n) begin
                start_in <= 1'b0;
            end
            #1;
            chk("held sample", {7'h00, sample_out}, 8'h00);
            chk("held trial", trial_code_out, 8'h00);
            chk("held done", {7'h00, conv_done_out}, {7'h00, d0});
        end
    endtask

    // =========================================================
    // scenarios
    // full conversion, walked edge by edge from the start fall
    task automatic run_conv(input logic [7:0] v, input logic [7:0] old, input logic d0,
                            input int n);
        int k;
        level = v;
        pulse_start(n, d0);
        for (int e = 1; e <= 66; e++) begin
            @(posedge clk_in);
            #1;
            chk("sample", {7'h00, sample_out}, {7'h00, e >= 4 && e < 8});
            chk("done", {7'h00, conv_done_out}, {7'h00, e < 8 ? d0 : e >= 65});
            chk("bus", result_bus_out, e >= 64 ? v : old);
            if (e >= 8 && e < 64 && (e - 8) % 7 == 0) begin
                k = (e - 8) / 7;
                chk("trial", trial_code_out, (v & ~(8'hFF >> k)) | (8'h80 >> k));
            end
        end
    endtask

    // every channel code, then a held strobe that must not recapture
    task automatic t_chan();
        for (int n = 0; n < NUM_CHAN; n++) begin
            @(posedge clk_in);
            channel_select_in <= 3'(n);
            addr_latch_in <= 1'b1;
            @(posedge clk_in) addr_latch_in <= 1'b0;
            @(posedge clk_in);
            #1;
            chk("channel", channel_onehot_out, 8'h01 << n);
        end
        @(posedge clk_in);
        channel_select_in <= 3'h2;
        addr_latch_in <= 1'b1;
        @(posedge clk_in) channel_select_in <= 3'h5;
        repeat (3) @(posedge clk_in);
        #1;
        chk("channel held", channel_onehot_out, 8'h04);
        @(posedge clk_in) addr_latch_in <= 1'b0;
    endtask

    // restart in mid-decision with a long start; old result must survive
    task automatic t_abort();
        level = 8'h3C;
        pulse_start(1, 1'b1);
        repeat (30) @(posedge clk_in);
        #1;
        run_conv(8'h5A, 8'h00, 1'b0, 4);
    endtask

    // bus enable follows the host read strobe
    task automatic t_oe();
        @(posedge clk_in) output_enable_in <= 1'b0;
        #1;
        chk("oe low", {7'h00, result_bus_oe_out}, 8'h00);
        @(posedge clk_in) output_enable_in <= 1'b1;
        #1;
        chk("oe high", {7'h00, result_bus_oe_out}, 8'h01);
        chk("bus read", result_bus_out, 8'h5A);
    endtask

    // =========================================================
    // main sequence and hang guard
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        chk("reset done", {7'h00, conv_done_out}, 8'h01);
        chk("reset bus", result_bus_out, 8'h00);
        t_chan();
        run_conv(8'hA5, 8'h00, 1'b1, 1);
        run_conv(8'hFF, 8'hA5, 1'b1, 1);
        run_conv(8'h00, 8'hFF, 1'b1, 1);
        t_abort();
        t_oe();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        test_done();
    end
endmodule
